// ### cdr_flags_and_signal_controls.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdr_flags_cfg.svh"

// What this block does
// [R1] Byte 5 bits 7-4 latch tx lock loss
// [R2] Byte 5 bits 3-0 latch rx lock loss
// [R3] Byte 98 bits 7-4 enable tx recovery
// [R4] Byte 98 bits 3-0 enable rx recovery
// [R5] Amplitude codes above 0011b are reserved
// [R6] Equalization codes above 1010b are reserved
// [R7] Emphasis codes above 0111b are reserved
// [R8] Fully functional within 2000 ms of start
// [R9] Reset pin counts only after 2 us low
// [R10] Serial bus answers within 2000 ms
// [R11] Clear not-ready bit and raise attention
// [R12] Functional within 2000 ms after reset release
// [R13] Reading flags clears them, drops attention
// [R14] Functional means attention raised on ready
// [R15] Lock loss stays latched until read
module cdr_flags_and_signal_controls
   import cdr_flags_pkg::*;
#(
   parameter int INIT_CYCLES   = `INIT_MAX_CYCLES,
   parameter int SERIAL_CYCLES = `SERIAL_MAX_CYCLES
) (
   // Clock and reset
   input  wire logic  clk_sys,
   input  wire logic  sys_rst,
   // Module pins
   input  wire logic  module_reset_n,
   input  wire logic  scl_in,
   input  wire logic  sda_in,
   output logic       sda_out,
   output logic       sda_oe,
   output logic       attention_out_n,
   // Clock recovery lock status from the lanes
   input  wire logic [3:0] tx_lock_lost,
   input  wire logic [3:0] rx_lock_lost,
   // Lane controls
   output cdr_enable_t cdr_enable,
   output lane_codes_t lane_codes
);

   localparam logic [`INIT_CNT_W-1:0]  INIT_LAST =
      `INIT_CNT_W'(INIT_CYCLES - 1);
   localparam logic [`INIT_CNT_W-1:0]  SERIAL_LAST =
      `INIT_CNT_W'(SERIAL_CYCLES - 1);
   localparam logic [`RESET_CNT_W-1:0] RESET_MIN =
      `RESET_CNT_W'(`RESET_MIN_CYCLES);

   state_t st_ff;
   state_t nxt_st;

   function automatic state_t init_state();
      state_t s;
      s        = '0;
      // Sync stages start at the idle pin levels so no false edge follows reset.
      s.sy.scl   = 2'b11;
      s.sy.sda   = 2'b11;
      s.sy.scl_p = 1'b1;
      s.sy.sda_p = 1'b1;
      s.sy.rst_n = 2'b11;
      s.dnr    = 1'b1;
      s.att_n  = 1'b1;
      s.cdr_en = `CDR_ENABLE_RESET;
      s.codes  = {`CODES_RESET, `CODES_RESET, `CODES_RESET};
      s.st     = BUS_IDLE;
      return s;
   endfunction : init_state

   // Each nibble is taken only if it is a legal code, else the old one stays.
   function automatic logic [7:0] keep_legal(input logic [7:0] old,
                                             input logic [7:0] wr,
                                             input logic [3:0] limit);
      logic [7:0] r;
      r = old;
      for (int i = 0; i < 2; i++) begin
         if (wr[i*4 +: 4] <= limit) begin
            r[i*4 +: 4] = wr[i*4 +: 4];
         end
      end
      return r;
   endfunction : keep_legal

   function automatic logic [7:0] rd_byte(input state_t s, input logic [7:0] a);
      logic [7:0] r;
      r = 8'h00;
      case (a)
         `ADDR_STATUS:     r[`DNR_BIT] = s.dnr;
         `ADDR_LOL_FLAGS:  r = s.flags;
         `ADDR_CDR_ENABLE: r = s.cdr_en;
         `ADDR_TX_EQ_HI:   r = s.codes.tx_eq[15:8];
         `ADDR_TX_EQ_LO:   r = s.codes.tx_eq[7:0];
         `ADDR_RX_EMPH_HI: r = s.codes.rx_emph[15:8];
         `ADDR_RX_EMPH_LO: r = s.codes.rx_emph[7:0];
         `ADDR_RX_AMP_HI:  r = s.codes.rx_amp[15:8];
         `ADDR_RX_AMP_LO:  r = s.codes.rx_amp[7:0];
         default:          r = 8'h00;
      endcase
      return r;
   endfunction : rd_byte

   always_comb begin
      logic       scl;
      logic       sda;
      logic       rise;
      logic       fall;
      logic       start;
      logic       stop;
      logic       bus_rdy;
      logic [7:0] rd;
      sync_t      sy;
      scl    = st_ff.sy.scl[1];
      sda    = st_ff.sy.sda[1];
      rise   = scl & ~st_ff.sy.scl_p;
      fall   = ~scl & st_ff.sy.scl_p;
      start  = scl & st_ff.sy.scl_p & st_ff.sy.sda_p & ~sda;
      stop   = scl & st_ff.sy.scl_p & ~st_ff.sy.sda_p & sda;
      rd     = 8'h00;
      nxt_st = st_ff;

      sy.scl   = {st_ff.sy.scl[0], scl_in};
      sy.sda   = {st_ff.sy.sda[0], sda_in};
      sy.scl_p = scl;
      sy.sda_p = sda;
      sy.rst_n = {st_ff.sy.rst_n[0], module_reset_n};
      sy.lol1  = {tx_lock_lost, rx_lock_lost};
      sy.lol2  = st_ff.sy.lol1;
      nxt_st.sy    = sy;
      nxt_st.sda_o = 1'b0;

      // [R9] reset pulse width
      if (st_ff.sy.rst_n[1]) begin
         nxt_st.rst_cnt = '0;
      end else if (st_ff.rst_cnt != RESET_MIN) begin
         nxt_st.rst_cnt = st_ff.rst_cnt + `RESET_CNT_W'(1);
      end

      // [R10] serial bus ready
      bus_rdy = !st_ff.dnr || (st_ff.init_cnt >= SERIAL_LAST);

      // [R8] [R12] initialisation timer
      if (st_ff.dnr) begin
         if (st_ff.init_cnt == INIT_LAST) begin
            nxt_st.dnr      = 1'b0;
            nxt_st.init_evt = 1'b1;
         end else begin
            nxt_st.init_cnt = st_ff.init_cnt + `INIT_CNT_W'(1);
         end
      end

      if (start) begin
         nxt_st.st     = BUS_ADDR;
         nxt_st.cnt    = 4'h0;
         nxt_st.sda_oe = 1'b0;
      end else if (stop) begin
         nxt_st.st     = BUS_IDLE;
         nxt_st.sda_oe = 1'b0;
      end else if (rise) begin
         case (st_ff.st)
            BUS_ADDR, BUS_REG, BUS_WDATA: begin
               nxt_st.shift = {st_ff.shift[6:0], sda};
               nxt_st.cnt   = st_ff.cnt + 4'h1;
            end
            BUS_RDATA: nxt_st.cnt = st_ff.cnt + 4'h1;
            BUS_RACK: nxt_st.st = sda ? BUS_IDLE : BUS_AACK;
            default: ;
         endcase
      end else if (fall) begin
         case (st_ff.st)
            BUS_ADDR: begin
               if (st_ff.cnt == 4'h8) begin
                  if (st_ff.shift[7:1] == `DEV_ADDR && bus_rdy) begin
                     nxt_st.sda_oe = 1'b1;
                     nxt_st.rw     = st_ff.shift[0];
                     nxt_st.st     = BUS_AACK;
                  end else begin
                     nxt_st.st = BUS_IDLE;
                  end
               end
            end
            BUS_AACK: begin
               nxt_st.cnt = 4'h0;
               if (st_ff.rw) begin
                  rd            = rd_byte(st_ff, st_ff.ptr);
                  nxt_st.shift  = rd;
                  nxt_st.sda_oe = ~rd[7];
                  nxt_st.ptr    = st_ff.ptr + 8'h01;
                  nxt_st.st     = BUS_RDATA;
                  // [R13] clear on read
                  if (st_ff.ptr == `ADDR_LOL_FLAGS) begin
                     nxt_st.flags = '0;
                  end
                  // A ready event raised in the same cycle wins over the clear.
                  if (st_ff.ptr == `ADDR_STATUS) begin
                     nxt_st.init_evt = st_ff.dnr && (st_ff.init_cnt == INIT_LAST);
                  end
               end else begin
                  nxt_st.sda_oe = 1'b0;
                  nxt_st.st     = BUS_REG;
               end
            end
            BUS_REG: begin
               if (st_ff.cnt == 4'h8) begin
                  nxt_st.ptr    = st_ff.shift;
                  nxt_st.sda_oe = 1'b1;
                  nxt_st.st     = BUS_WACK;
               end
            end
            BUS_WACK: begin
               nxt_st.sda_oe = 1'b0;
               nxt_st.cnt    = 4'h0;
               nxt_st.st     = BUS_WDATA;
            end
            BUS_WDATA: begin
               if (st_ff.cnt == 4'h8) begin
                  nxt_st.ptr    = st_ff.ptr + 8'h01;
                  nxt_st.sda_oe = 1'b1;
                  nxt_st.st     = BUS_WACK;
                  case (st_ff.ptr)
                     // [R3] [R4] recovery enables
                     `ADDR_CDR_ENABLE: nxt_st.cdr_en = st_ff.shift;
                     // [R6] legal equalization codes
                     `ADDR_TX_EQ_HI: nxt_st.codes.tx_eq[15:8] =
                        keep_legal(st_ff.codes.tx_eq[15:8], st_ff.shift, `LIMIT_TX_EQ);
                     `ADDR_TX_EQ_LO: nxt_st.codes.tx_eq[7:0] =
                        keep_legal(st_ff.codes.tx_eq[7:0], st_ff.shift, `LIMIT_TX_EQ);
                     // [R7] legal emphasis codes
                     `ADDR_RX_EMPH_HI: nxt_st.codes.rx_emph[15:8] =
                        keep_legal(st_ff.codes.rx_emph[15:8], st_ff.shift, `LIMIT_RX_EMPH);
                     `ADDR_RX_EMPH_LO: nxt_st.codes.rx_emph[7:0] =
                        keep_legal(st_ff.codes.rx_emph[7:0], st_ff.shift, `LIMIT_RX_EMPH);
                     // [R5] legal amplitude codes
                     `ADDR_RX_AMP_HI: nxt_st.codes.rx_amp[15:8] =
                        keep_legal(st_ff.codes.rx_amp[15:8], st_ff.shift, `LIMIT_RX_AMP);
                     `ADDR_RX_AMP_LO: nxt_st.codes.rx_amp[7:0] =
                        keep_legal(st_ff.codes.rx_amp[7:0], st_ff.shift, `LIMIT_RX_AMP);
                     default: ;
                  endcase
               end
            end
            BUS_RDATA: begin
               if (st_ff.cnt == 4'h8) begin
                  nxt_st.sda_oe = 1'b0;
                  nxt_st.st     = BUS_RACK;
               end else begin
                  nxt_st.shift  = {st_ff.shift[6:0], 1'b0};
                  nxt_st.sda_oe = ~st_ff.shift[6];
               end
            end
            default: ;
         endcase
      end

      // [R1] [R2] [R15] latch lock loss, set wins over clear
      nxt_st.flags = nxt_st.flags | lol_flags_t'(st_ff.sy.lol2);

      // [R11] [R14] [R13] attention from pending events
      nxt_st.att_n = ~(st_ff.init_evt | (|st_ff.flags));

      // [R9] [R12] a valid reset pulse holds everything but the sync stages and reset counter in its start state
      if (st_ff.rst_cnt == RESET_MIN) begin
         nxt_st         = init_state();
         nxt_st.sy      = sy;
         nxt_st.rst_cnt = st_ff.rst_cnt;
         if (st_ff.sy.rst_n[1]) begin
            nxt_st.rst_cnt = '0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         st_ff <= init_state();
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign sda_out         = st_ff.sda_o;
   assign sda_oe          = st_ff.sda_oe;
   assign attention_out_n = st_ff.att_n;
   assign cdr_enable      = st_ff.cdr_en;
   assign lane_codes      = st_ff.codes;

endmodule : cdr_flags_and_signal_controls

`default_nettype wire

// ### cdr_flags_and_signal_controls_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdr_flags_cfg.svh"
module cdr_flags_props
   import cdr_flags_pkg::*;
#(
   parameter int INIT_CYCLES   = 200,
   parameter int SERIAL_CYCLES = 100
) (
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        sys_rst,
   // Pins
   input wire logic        module_reset_n,
   input wire logic        scl_in,
   input wire logic        sda_in,
   input wire logic        sda_out,
   input wire logic        sda_oe,
   input wire logic        attention_out_n,
   // Lanes
   input wire logic [3:0]  tx_lock_lost,
   input wire logic [3:0]  rx_lock_lost,
   input wire cdr_enable_t cdr_enable,
   input wire lane_codes_t lane_codes
);
   int   up_ff;
   int   low_ff;
   logic rdy;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   assign rdy = up_ff >= INIT_CYCLES + 8;
   // Cycles since the last accepted reset; a short pulse on the pin does not restart it.
   always_ff @(posedge clk_sys) begin
      low_ff <= module_reset_n ? 0 : low_ff + 1;
      up_ff  <= (sys_rst || low_ff >= `RESET_MIN_CYCLES) ? 0 : up_ff + 1;
   end
   function automatic logic nib_ok(input logic [15:0] v, input logic [3:0] lim);
      return v[15:12] <= lim && v[11:8] <= lim && v[7:4] <= lim && v[3:0] <= lim;
   endfunction : nib_ok
   sequence s_ack;
      ##[0:2] sda_oe;
   endsequence
   property p_rst_state;
      $fell(sys_rst) |-> !sda_oe && attention_out_n && cdr_enable == 8'h00
         && lane_codes == 48'h0;
   endproperty
   property p_quiet;
      up_ff < SERIAL_CYCLES - 2 |-> !sda_oe;
   endproperty
   property p_ready;
      up_ff == INIT_CYCLES + 8 |-> !attention_out_n;
   endproperty
   property p_amp;
      nib_ok(lane_codes.rx_amp, `LIMIT_RX_AMP);
   endproperty
   property p_eq;
      nib_ok(lane_codes.tx_eq, `LIMIT_TX_EQ);
   endproperty
   property p_emph;
      nib_ok(lane_codes.rx_emph, `LIMIT_RX_EMPH);
   endproperty
   property p_lost;
      rdy && (tx_lock_lost != 4'h0 || rx_lock_lost != 4'h0) |-> ##[1:8] !attention_out_n;
   endproperty
   property p_cfg;
      up_ff >= SERIAL_CYCLES && ($changed(cdr_enable) || $changed(lane_codes)) |-> s_ack;
   endproperty
   property p_release;
      $rose(attention_out_n) && rdy |-> $past(tx_lock_lost | rx_lock_lost, 3) == 4'h0;
   endproperty
   a_rst_state: assert property (p_rst_state) else $error("bad state after reset");
   a_quiet: assert property (p_quiet) else $error("bus answered too early");
   a_ready: assert property (p_ready) else $error("attention not raised when ready");
   a_amp: assert property (p_amp) else $error("reserved amplitude code held");
   a_eq: assert property (p_eq) else $error("reserved equalization code held");
   a_emph: assert property (p_emph) else $error("reserved emphasis code held");
   a_lost: assert property (p_lost) else $error("lock loss not flagged");
   a_cfg: assert property (p_cfg) else $error("control changed without a write");
   a_release: assert property (p_release) else $error("attention released early");
endmodule : cdr_flags_props
bind cdr_flags_and_signal_controls cdr_flags_props #(
   .INIT_CYCLES(INIT_CYCLES), .SERIAL_CYCLES(SERIAL_CYCLES)
) props_u (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .module_reset_n(module_reset_n), .scl_in(scl_in),
   .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .attention_out_n(attention_out_n),
   .tx_lock_lost(tx_lock_lost), .rx_lock_lost(rx_lock_lost), .cdr_enable(cdr_enable),
   .lane_codes(lane_codes)
);
`default_nettype wire

// ### cdr_flags_and_signal_controls_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "cdr_flags_cfg.svh"
module cdr_flags_and_signal_controls_tb
   import cdr_flags_pkg::*;
;
   localparam int INIT = 200;
   localparam int SER  = 150;
   logic        clk_sys;
   logic        sys_rst;
   logic        module_reset_n;
   logic        scl;
   logic        host_oe;
   logic        sda_out;
   logic        sda_oe;
   logic        attention_out_n;
   logic [3:0]  tx_lock_lost;
   logic [3:0]  rx_lock_lost;
   cdr_enable_t cdr_enable;
   lane_codes_t lane_codes;
   wire logic   sda_w = !(sda_oe | host_oe);
   int          err_total;
   int          n_compared;
   int          cyc;
   logic        ack;
   logic [7:0]  rv;
   cdr_flags_and_signal_controls #(.INIT_CYCLES(INIT), .SERIAL_CYCLES(SER)) dut_u (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .module_reset_n(module_reset_n), .scl_in(scl),
      .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .attention_out_n(attention_out_n),
      .tx_lock_lost(tx_lock_lost), .rx_lock_lost(rx_lock_lost), .cdr_enable(cdr_enable),
      .lane_codes(lane_codes));
   cdr_host_model host_u (.sda_in(sda_w), .scl(scl), .host_oe(host_oe));
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : step
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t mismatch got %0h exp %0h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [47:0] d, input int n);
      host_u.start();
      host_u.wbyte({`DEV_ADDR, 1'b0}, ack);
      chk(ack, 1'b1);
      host_u.wbyte(a, ack);
      for (int i = n - 1; i >= 0; i--) begin
         host_u.wbyte(d[i*8 +: 8], ack);
      end
      host_u.stop();
      step(2);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      host_u.start();
      host_u.wbyte({`DEV_ADDR, 1'b0}, ack);
      host_u.wbyte(a, ack);
      host_u.start();
      host_u.wbyte({`DEV_ADDR, 1'b1}, ack);
      host_u.rbyte(1'b1, v);
      host_u.stop();
      step(2);
   endtask : rd
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : print_verdict
   task automatic t_startup();
      host_u.start();
      host_u.wbyte({`DEV_ADDR, 1'b0}, ack);
      host_u.stop();
      step(2);
      chk(ack, 1'b0);
      chk(sda_out, 1'b0);
      step(INIT + 10);
      chk(attention_out_n, 1'b0);
      rd(`ADDR_STATUS, rv);
      chk(rv[`DNR_BIT], 1'b0);
      step(4);
      chk(attention_out_n, 1'b1);
   endtask : t_startup
   task automatic t_cfg();
      wr(`ADDR_CDR_ENABLE, 48'hA5, 1);
      chk(cdr_enable, 8'hA5);
      rd(`ADDR_CDR_ENABLE, rv);
      chk(rv, 8'hA5);
   endtask : t_cfg
   // Every reserved form is written beside a legal nibble in the same byte.
   task automatic t_codes();
      wr(`ADDR_TX_EQ_HI, 48'hAB5C7F083421, 6);
      chk(lane_codes.tx_eq, 16'hA050);
      chk(lane_codes.rx_emph, 16'h7000);
      chk(lane_codes.rx_amp, 16'h3021);
      rd(`ADDR_TX_EQ_HI, rv);
      chk(rv, 8'hA0);
   endtask : t_codes
   task automatic t_flags();
      tx_lock_lost = 4'h5;
      rx_lock_lost = 4'h8;
      step(20);
      tx_lock_lost = 4'h0;
      rx_lock_lost = 4'h0;
      step(10);
      chk(attention_out_n, 1'b0);
      rd(`ADDR_LOL_FLAGS, rv);
      chk(rv, {4'h5, 4'h8});
      rd(`ADDR_LOL_FLAGS, rv);
      chk(rv, 8'h00);
      chk(attention_out_n, 1'b1);
   endtask : t_flags
   task automatic t_reset();
      module_reset_n = 1'b0;
      step(300);
      module_reset_n = 1'b1;
      step(10);
      chk(cdr_enable, 8'hA5);
      module_reset_n = 1'b0;
      step(`RESET_MIN_CYCLES + 10);
      chk(cdr_enable, 8'h00);
      chk(attention_out_n, 1'b1);
      module_reset_n = 1'b1;
      step(INIT + 10);
      chk(attention_out_n, 1'b0);
   endtask : t_reset
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end
   initial begin
      sys_rst = 1'b1;
      module_reset_n = 1'b1;
      tx_lock_lost = 4'h0;
      rx_lock_lost = 4'h0;
      step(5);
      sys_rst = 1'b0;
      t_startup();
      t_cfg();
      t_codes();
      t_flags();
      t_reset();
      print_verdict();
   end
endmodule : cdr_flags_and_signal_controls_tb
`default_nettype wire

// ### cdr_flags_cfg.svh
`ifndef CDR_FLAGS_CFG_SVH
`define CDR_FLAGS_CFG_SVH

// Management bus device address (7 bits) and register byte addresses.
`define DEV_ADDR          7'h50
`define ADDR_STATUS       8'h02
`define ADDR_LOL_FLAGS    8'h05
`define ADDR_CDR_ENABLE   8'h62
`define ADDR_TX_EQ_HI     8'hEA
`define ADDR_TX_EQ_LO     8'hEB
`define ADDR_RX_EMPH_HI   8'hEC
`define ADDR_RX_EMPH_LO   8'hED
`define ADDR_RX_AMP_HI    8'hEE
`define ADDR_RX_AMP_LO    8'hEF

// Field positions and reset values.
`define DNR_BIT           0
`define CDR_ENABLE_RESET  8'h00
`define CODES_RESET       16'h0000

// Highest legal code of each 4-bit lane field.
`define LIMIT_RX_AMP      4'h3
`define LIMIT_TX_EQ       4'hA
`define LIMIT_RX_EMPH     4'h7

// Timing.
`define CLK_MHZ           200
`define RESET_MIN_US      2
`define RESET_MIN_CYCLES  (`RESET_MIN_US * `CLK_MHZ)
`define RESET_CNT_W       9
`define INIT_MAX_MS       2000
`define INIT_MAX_CYCLES   (`INIT_MAX_MS * 1000 * `CLK_MHZ)
`define SERIAL_MAX_MS     2000
`define SERIAL_MAX_CYCLES (`SERIAL_MAX_MS * 1000 * `CLK_MHZ)
`define INIT_CNT_W        29

`endif

// ### cdr_flags_pkg.sv
`include "cdr_flags_cfg.svh"

package cdr_flags_pkg;

   typedef enum logic [3:0] {
      BUS_IDLE  = 4'b0000,
      BUS_ADDR  = 4'b0001,
      BUS_AACK  = 4'b0010,
      BUS_REG   = 4'b0011,
      BUS_WACK  = 4'b0100,
      BUS_WDATA = 4'b0101,
      BUS_RDATA = 4'b0110,
      BUS_RACK  = 4'b0111
   } bus_state_t;

   typedef struct packed {
      logic tx_lane4_lock_lost_latched;
      logic tx_lane3_lock_lost_latched;
      logic tx_lane2_lock_lost_latched;
      logic tx_lane1_lock_lost_latched;
      logic rx_lane4_lock_lost_latched;
      logic rx_lane3_lock_lost_latched;
      logic rx_lane2_lock_lost_latched;
      logic rx_lane1_lock_lost_latched;
   } lol_flags_t;

   typedef struct packed {
      logic tx_lane4_recovery_enable;
      logic tx_lane3_recovery_enable;
      logic tx_lane2_recovery_enable;
      logic tx_lane1_recovery_enable;
      logic rx_lane4_recovery_enable;
      logic rx_lane3_recovery_enable;
      logic rx_lane2_recovery_enable;
      logic rx_lane1_recovery_enable;
   } cdr_enable_t;

   typedef struct packed {
      logic [15:0] tx_eq;
      logic [15:0] rx_emph;
      logic [15:0] rx_amp;
   } lane_codes_t;

   typedef struct packed {
      logic [1:0] scl;
      logic [1:0] sda;
      logic       scl_p;
      logic       sda_p;
      logic [1:0] rst_n;
      logic [7:0] lol1;
      logic [7:0] lol2;
   } sync_t;

   typedef struct packed {
      sync_t                    sy;
      logic [`RESET_CNT_W-1:0]  rst_cnt;
      logic [`INIT_CNT_W-1:0]   init_cnt;
      logic                     dnr;
      logic                     init_evt;
      lol_flags_t               flags;
      cdr_enable_t              cdr_en;
      lane_codes_t              codes;
      bus_state_t               st;
      logic [3:0]               cnt;
      logic [7:0]               shift;
      logic [7:0]               ptr;
      logic                     rw;
      logic                     sda_o;
      logic                     sda_oe;
      logic                     att_n;
   } state_t;

endpackage : cdr_flags_pkg

// ### cdr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module cdr_host_model (
   // Data line level
   input  wire logic sda_in,
   // Host drive
   output logic      scl,
   output logic      host_oe
);
   initial begin
      scl = 1'b1;
      host_oe = 1'b0;
   end
   // Data moves mid-low so it never changes while the clock is high.
   task automatic bit_x(input logic b, output logic r);
      #12 host_oe = !b;
      #12 scl = 1'b1;
      #24 r = sda_in;
      scl = 1'b0;
   endtask : bit_x
   task automatic start();
      #12 host_oe = 1'b0;
      #12 scl = 1'b1;
      #24 host_oe = 1'b1;
      #24 scl = 1'b0;
   endtask : start
   task automatic stop();
      #12 host_oe = 1'b1;
      #12 scl = 1'b1;
      #24 host_oe = 1'b0;
      #24;
   endtask : stop
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'b1, r);
      ack = !r;
   endtask : wbyte
   task automatic rbyte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(last, r);
   endtask : rbyte
endmodule : cdr_host_model
`default_nettype wire
